// ### rtl/dcdc_fault_sleep_irq.sv
// converter sleep control, fault action, blanking, filtering and uv interrupt
// assumes apb master on ref_clk; analogue comparator and enable inputs are async
// Operation
// - a boost converter with its sleep action bit 0 runs on in sleep, with 1 it is off.
// - the sleep source field picks the global bit, or line 1, 2 or 3, for codes 00 to 11.
// - an asserted sleep input pin forces sleep behaviour regardless of source.
// - undervoltage is flagged when an output falls below 95 percent of target.
// - each converter has a fault action field reset to 00: ignore, converter off, system off.
// - fault action code 11 acts like system shutdown.
// - every fault sets its interrupt flag whatever the fault action.
// - a fault is reported only if it persists, so brief surges are ignored.
// - faults from a just-started converter are ignored until blanking time has passed.
// - one blanking field for all converters, reset 00, selects 0.5, 2, 32 or 256 ms.
// - the summary interrupt combines all six converter flags and the regulator flags.
// - each converter has a uv flag set on a rising edge, converter 1 at bit 0 to 6 at bit 5.
// - reading the status register clears the flags that the read returned set.
// - the mask has the status layout and a 1 stops that flag driving the summary.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
module dcdc_fault_sleep_irq
  import dcdc_fault_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = PERSIST_DEF,
  parameter int unsigned BLANK0_CYC     = BLANK0_US * CYC_PER_US,
  parameter int unsigned BLANK1_CYC     = BLANK1_US * CYC_PER_US,
  parameter int unsigned BLANK2_CYC     = BLANK2_US * CYC_PER_US,
  parameter int unsigned BLANK3_CYC     = BLANK3_US * CYC_PER_US
)(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_CONV-1:0] conv_enable,
  input  wire logic [NUM_CONV-1:0] conv_below_95pct,
  input  wire logic                regulator_uv_irq,
  input  wire logic                low_power_line_1,
  input  wire logic                low_power_line_2,
  input  wire logic                low_power_line_3,
  input  wire logic                sleep_pin,
  input  wire logic                sleep_request,
  output logic      [NUM_CONV-1:0] conv_output_on,
  output logic                     system_shutdown,
  output logic                     undervoltage_summary_irq
);
  localparam int unsigned PW = $clog2(PERSIST_CYCLES + 1);
  localparam int unsigned BW = $clog2(BLANK3_CYC + 1);
  localparam int unsigned NS = NUM_CONV + 5;
  localparam logic [PW-1:0] PERSIST_MAX = PW'(PERSIST_CYCLES);

  // pin synchronisers; stage one read only by stage two
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic [NUM_CONV-1:0] en_sync1_reg;
  logic [NUM_CONV-1:0] en_sync_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      en_sync1_reg <= '0;
      en_sync_reg  <= '0;
    end else begin
      sync1_reg <= {regulator_uv_irq, sleep_pin, low_power_line_3, low_power_line_2,
                    low_power_line_1, conv_below_95pct};
      sync2_reg <= sync1_reg;
      en_sync1_reg <= conv_enable;
      en_sync_reg  <= en_sync1_reg;
    end
  end

  logic [NUM_CONV-1:0] uv_raw;
  logic                line1;
  logic                line2;
  logic                line3;
  logic                pin_sleep;
  logic                ldo_uv;
  assign uv_raw    = sync2_reg[NUM_CONV-1:0];
  assign line1     = sync2_reg[NUM_CONV];
  assign line2     = sync2_reg[NUM_CONV+1];
  assign line3     = sync2_reg[NUM_CONV+2];
  assign pin_sleep = sync2_reg[NUM_CONV+3];
  assign ldo_uv    = sync2_reg[NUM_CONV+4];

  // registers
  logic [REG_W-1:0]    mode2_reg;
  logic [REG_W-1:0]    mode5_reg;
  logic [REG_W-1:0]    actopt_reg;
  logic [1:0]          fault_act_reg [NUM_CONV];
  logic [NUM_CONV-1:0] uv_status_reg;
  logic [NUM_CONV-1:0] uv_mask_reg;
  logic                global_sleep_reg;

  logic [7:0]  idx;
  logic        setup_rd;
  logic        wr_en;
  logic        rd_status;
  logic [15:0] wdata16;
  assign idx       = paddr[9:2];
  assign wr_en     = psel && penable && pwrite;
  assign setup_rd  = psel && !penable && !pwrite;
  assign rd_status = psel && penable && !pwrite && !pslverr && (idx == IDX_UV_STATUS);
  assign pready    = 1'b1;

  function automatic logic [15:0] strb_merge(input logic [15:0] old_v,
                                             input logic [15:0] mask);
    logic [15:0] nv;
    nv = old_v;
    if (pstrb[0]) nv[7:0]  = pwdata[7:0];
    if (pstrb[1]) nv[15:8] = pwdata[15:8];
    strb_merge = nv & mask;
  endfunction : strb_merge

  function automatic int conv_of_fault_idx(input logic [7:0] a);
    unique case (a)
      IDX_CONV1_FAULT: conv_of_fault_idx = 0;
      IDX_CONV2_FAULT: conv_of_fault_idx = 1;
      IDX_CONV3_FAULT: conv_of_fault_idx = 2;
      IDX_CONV4_FAULT: conv_of_fault_idx = 3;
      IDX_CONV5_FAULT: conv_of_fault_idx = 4;
      IDX_CONV6_FAULT: conv_of_fault_idx = 5;
      default:         conv_of_fault_idx = -1;
    endcase
  endfunction : conv_of_fault_idx

  // every mapped index; any other answers with an error and reads zero
  function automatic logic reg_mapped(input logic [7:0] a);
    unique case (a)
      IDX_UV_STATUS,
      IDX_UV_MASK,
      IDX_ACTIVE_OPT,
      IDX_CONV2_MODE,
      IDX_CONV5_MODE,
      IDX_SLEEP_CTRL,
      IDX_BLOCK_STATUS: reg_mapped = 1'b1;
      default:          reg_mapped = conv_of_fault_idx(a) >= 0;
    endcase
  endfunction : reg_mapped

  // only aligned words in the low window decode
  function automatic logic addr_legal(input logic [11:0] a);
    addr_legal = a[11:10] == 2'b00 && a[1:0] == 2'b00 && reg_mapped(a[9:2]);
  endfunction : addr_legal

  // pready is tied high, so every access completes in its first cycle
  logic addr_ok;
  assign addr_ok = addr_legal(paddr);
  assign pslverr = psel && penable && !addr_ok;

  // one write decode for the single registers, the fault action fields decode inline; refused transfers never land
  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr_en && !pslverr && idx == a;
  endfunction : wr_hit

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode2_reg <= MODE_RESET;
    end else if (wr_hit(IDX_CONV2_MODE)) begin
      mode2_reg <= strb_merge(mode2_reg, MODE_WR_MASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode5_reg <= MODE_RESET;
    end else if (wr_hit(IDX_CONV5_MODE)) begin
      mode5_reg <= strb_merge(mode5_reg, MODE_WR_MASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      actopt_reg <= ZERO16;
    end else if (wr_hit(IDX_ACTIVE_OPT)) begin
      actopt_reg <= strb_merge(actopt_reg, ACTOPT_WR_MASK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      uv_mask_reg <= '0;
    end else if (wr_hit(IDX_UV_MASK) && pstrb[0]) begin
      uv_mask_reg <= pwdata[NUM_CONV-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      global_sleep_reg <= 1'b0;
    end else if (wr_hit(IDX_SLEEP_CTRL) && pstrb[0]) begin
      global_sleep_reg <= pwdata[0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_fact
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          fault_act_reg[g] <= ACT_IGNORE;
        end else if (wr_en && !pslverr && conv_of_fault_idx(idx) == g && pstrb[1]) begin
          fault_act_reg[g] <= pwdata[FAULT_ACT_LSB +: 2];
        end
      end
    end
  endgenerate

  // sleep decision for the two boost converters
  function automatic logic sleep_sel(input logic [15:0] m);
    logic s;
    unique case (m[SLEEP_SRC_LSB +: 2])
      // sleep_request is a same-clock level, so it has no synchroniser
      SRC_GLOBAL: s = global_sleep_reg || sleep_request;
      SRC_LINE1:  s = line1;
      SRC_LINE2:  s = line2;
      SRC_LINE3:  s = line3;
    endcase
    sleep_sel = s || pin_sleep;
  endfunction : sleep_sel

  logic [NUM_CONV-1:0] sleep_off;
  always_comb begin
    sleep_off    = '0;
    sleep_off[1] = sleep_sel(mode2_reg) && mode2_reg[SLEEP_ACT_BIT];
    sleep_off[4] = sleep_sel(mode5_reg) && mode5_reg[SLEEP_ACT_BIT];
  end

  // blanking, persistence and fault reaction per converter
  logic [BW-1:0] blank_len;
  always_comb begin
    unique case (actopt_reg[BLANK_LSB +: 2])
      2'b00: blank_len = BW'(BLANK0_CYC);
      2'b01: blank_len = BW'(BLANK1_CYC);
      2'b10: blank_len = BW'(BLANK2_CYC);
      2'b11: blank_len = BW'(BLANK3_CYC);
    endcase
  end

  logic [NUM_CONV-1:0] fault_q;
  logic [NUM_CONV-1:0] fault_prev_reg;
  logic [NUM_CONV-1:0] conv_tripped_reg;
  logic [NUM_CONV-1:0] sys_req;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_conv
      logic [BW-1:0] blank_cnt_reg;
      logic [PW-1:0] pers_cnt_reg;
      logic          en_prev_reg;
      logic          blanking;
      assign blanking = blank_cnt_reg != '0;
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          blank_cnt_reg <= '0;
          en_prev_reg   <= 1'b0;
        end else begin
          en_prev_reg <= en_sync_reg[g];
          if (en_sync_reg[g] && !en_prev_reg) begin
            blank_cnt_reg <= blank_len;
          end else if (!en_sync_reg[g]) begin
            blank_cnt_reg <= '0;
          end else if (blanking) begin
            blank_cnt_reg <= blank_cnt_reg - BW'(1);
          end
        end
      end
      // counter saturates; a single gap restarts it, so surges never count
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          pers_cnt_reg <= '0;
        end else if (!uv_raw[g] || blanking || !en_sync_reg[g]) begin
          pers_cnt_reg <= '0;
        end else if (pers_cnt_reg != PERSIST_MAX) begin
          pers_cnt_reg <= pers_cnt_reg + PW'(1);
        end
      end
      assign fault_q[g] = pers_cnt_reg == PERSIST_MAX;
      assign sys_req[g] = fault_q[g] && fault_act_reg[g][1];
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          conv_tripped_reg[g] <= 1'b0;
        end else if (!en_sync_reg[g]) begin
          conv_tripped_reg[g] <= 1'b0;
        end else if (fault_q[g] && fault_act_reg[g] == ACT_CONV_OFF) begin
          conv_tripped_reg[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // shutdown latches until reset; the power sequencer owns the recovery
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      system_shutdown <= 1'b0;
    end else if (|sys_req) begin
      system_shutdown <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      conv_output_on <= '0;
    end else begin
      // registered so no decode glitch reaches a converter enable
      conv_output_on <= en_sync_reg & ~sleep_off & ~conv_tripped_reg
                        & {NUM_CONV{!system_shutdown}};
    end
  end

  // status: set on filtered rising edge, set beats the read clear
  logic [NUM_CONV-1:0] uv_rise;
  logic [NUM_CONV-1:0] rd_snap_reg;
  assign uv_rise = fault_q & ~fault_prev_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fault_prev_reg <= '0;
      uv_status_reg  <= '0;
    end else begin
      fault_prev_reg <= fault_q;
      // flag raised whatever the action field holds
      uv_status_reg  <= (uv_status_reg & ~(rd_status ? rd_snap_reg : '0)) | uv_rise;
    end
  end
  // clear exactly what the read returned, captured at setup
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_snap_reg <= '0;
    end else if (setup_rd) begin
      rd_snap_reg <= uv_status_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      undervoltage_summary_irq <= 1'b0;
    end else begin
      undervoltage_summary_irq <= |(uv_status_reg & ~uv_mask_reg) || ldo_uv;
    end
  end

  // status shows the live flags; the snapshot taken alongside drives the clear
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (conv_of_fault_idx(idx) >= 0) begin
      rd_word[FAULT_ACT_LSB +: 2] = fault_act_reg[conv_of_fault_idx(idx)];
    end
    unique case (idx)
      IDX_UV_STATUS:    rd_word[NUM_CONV-1:0] = uv_status_reg;
      IDX_UV_MASK:      rd_word[NUM_CONV-1:0] = uv_mask_reg;
      IDX_ACTIVE_OPT:   rd_word[15:0] = actopt_reg;
      IDX_CONV2_MODE:   rd_word[15:0] = mode2_reg;
      IDX_CONV5_MODE:   rd_word[15:0] = mode5_reg;
      IDX_SLEEP_CTRL:   rd_word[0] = global_sleep_reg;
      IDX_BLOCK_STATUS: rd_word[15:0] = {2'b00, system_shutdown, conv_tripped_reg,
                                          1'b0, conv_output_on};
      default: ;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setup_rd) begin
      // refused reads return zero
      prdata <= addr_ok ? rd_word : '0;
    end
  end
endmodule : dcdc_fault_sleep_irq

// ### rtl/dcdc_fault_pkg.sv
// constants for the converter fault, sleep and undervoltage interrupt block
// assumes a single 25 MHz clock and a 32-bit apb register bus
package dcdc_fault_pkg;
  localparam int unsigned NUM_CONV = 6;
  localparam int unsigned CLK_HZ   = 25000000;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_UV_STATUS    = 8'h1c;
  localparam logic [7:0] IDX_UV_MASK      = 8'h24;
  localparam logic [7:0] IDX_ACTIVE_OPT   = 8'hb1;
  localparam logic [7:0] IDX_CONV1_FAULT  = 8'hb5;
  localparam logic [7:0] IDX_CONV2_MODE   = 8'hb7;
  localparam logic [7:0] IDX_CONV2_FAULT  = 8'hb8;
  localparam logic [7:0] IDX_CONV3_FAULT  = 8'hbb;
  localparam logic [7:0] IDX_CONV4_FAULT  = 8'hbe;
  localparam logic [7:0] IDX_CONV5_MODE   = 8'hc0;
  localparam logic [7:0] IDX_CONV5_FAULT  = 8'hc1;
  localparam logic [7:0] IDX_CONV6_FAULT  = 8'hc4;
  localparam logic [7:0] IDX_SLEEP_CTRL   = 8'hd0;
  localparam logic [7:0] IDX_BLOCK_STATUS = 8'hd1;

  // field positions
  localparam int unsigned SLEEP_ACT_BIT   = 12;
  localparam int unsigned SLEEP_SRC_LSB   = 8;
  localparam int unsigned FAULT_ACT_LSB   = 14;
  localparam int unsigned BLANK_LSB       = 12;
  localparam int unsigned REG_W           = 16;

  localparam logic [15:0] MODE_WR_MASK    = 16'h135f;
  localparam logic [15:0] FAULT_WR_MASK   = 16'hc000;
  localparam logic [15:0] ACTOPT_WR_MASK  = 16'h3000;
  localparam logic [15:0] MODE_RESET      = 16'h0008;
  localparam logic [15:0] ZERO16          = 16'h0000;

  localparam logic [1:0] SRC_GLOBAL = 2'b00;
  localparam logic [1:0] SRC_LINE1  = 2'b01;
  localparam logic [1:0] SRC_LINE2  = 2'b10;
  localparam logic [1:0] SRC_LINE3  = 2'b11;

  localparam logic [1:0] ACT_IGNORE   = 2'b00;
  localparam logic [1:0] ACT_CONV_OFF = 2'b01;

  // blanking times in microseconds
  localparam int unsigned BLANK0_US = 500;
  localparam int unsigned BLANK1_US = 2000;
  localparam int unsigned BLANK2_US = 32000;
  localparam int unsigned BLANK3_US = 256000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
  localparam int unsigned PERSIST_DEF = 64;
endpackage : dcdc_fault_pkg

// ### tb/dcdc_fault_chk.sv
// port-level assertions for the converter fault and uv interrupt block
// assumes one clock and a bench using short persistence and blanking counts
`timescale 1ns/1ps
module dcdc_fault_chk
  import dcdc_fault_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_CONV-1:0] conv_enable,
  input wire logic [NUM_CONV-1:0] conv_below_95pct,
  input wire logic                regulator_uv_irq,
  input wire logic [NUM_CONV-1:0] conv_output_on,
  input wire logic                system_shutdown,
  input wire logic                undervoltage_summary_irq
);
  logic       cause;
  logic [3:0] quiet_reg;
  // anything that may raise a flag; sync plus filter settle well inside 8 cycles
  assign cause = (conv_below_95pct != '0) || regulator_uv_irq || (psel && penable && pwrite);
  always_ff @(posedge ref_clk) begin
    if (rst || cause) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hf) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  err_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  shut_sticky_a: assert property (system_shutdown |=> system_shutdown)
    else $error("shutdown released without reset");
  shut_gate_a: assert property (system_shutdown |=> conv_output_on == '0)
    else $error("converter on during shutdown");
  enable_gate_a: assert property ((conv_enable == '0) [*4] |-> conv_output_on == '0)
    else $error("converter on while not enabled");
  irq_cause_a: assert property ($rose(undervoltage_summary_irq) |-> $past(quiet_reg) < 4'h8)
    else $error("summary rose without a persistent cause");
  shut_cause_a: assert property ($rose(system_shutdown) |-> $past(quiet_reg) < 4'h8)
    else $error("shutdown without a persistent fault");
  reg_uv_a: assert property (regulator_uv_irq [*4] |-> undervoltage_summary_irq)
    else $error("regulator uv not in summary");
  cover property ($rose(system_shutdown));
  cover property ($rose(undervoltage_summary_irq));
  cover property (psel && penable && pslverr);
endmodule : dcdc_fault_chk

bind dcdc_fault_sleep_irq dcdc_fault_chk u_chk (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_enable(conv_enable),
  .conv_below_95pct(conv_below_95pct), .regulator_uv_irq(regulator_uv_irq),
  .conv_output_on(conv_output_on), .system_shutdown(system_shutdown),
  .undervoltage_summary_irq(undervoltage_summary_irq));

// ### tb/testbench.sv
// self-checking bench for the converter fault, sleep and uv interrupt block
// assumes short persistence and blanking counts set at the instance
`timescale 1ns/1ps
module testbench import dcdc_fault_pkg::*; ;
  logic                ref_clk, rst, psel, penable, pwrite, reg_uv, sleep_pin, sleep_request;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata;
  logic [3:0]          pstrb;
  logic                pready, pslverr, shut, irq;
  logic [2:0]          lp;
  logic [NUM_CONV-1:0] en, uv, on;
  logic [7:0]          fidx [6];
  int                  bad_count = 0;
  int                  tests_run = 0;

  dcdc_fault_sleep_irq #(.PERSIST_CYCLES(4), .BLANK0_CYC(20), .BLANK1_CYC(40),
                         .BLANK2_CYC(60), .BLANK3_CYC(80)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_enable(en), .conv_below_95pct(uv), .regulator_uv_irq(reg_uv),
    .low_power_line_1(lp[0]), .low_power_line_2(lp[1]), .low_power_line_3(lp[2]),
    .sleep_pin(sleep_pin), .sleep_request(sleep_request), .conv_output_on(on),
    .system_shutdown(shut), .undervoltage_summary_irq(irq));

  initial begin
    ref_clk = 1'h0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  // one transfer; waits on pready, the watchdog bounds a hang
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {16'h0, wd};
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [15:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'h1, idx, v, d, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic eerr);
    logic [31:0] d;
    logic        e;
    apb(1'h0, idx, 16'h0, d, e);
    check(d, exp);
    chk1(e, eerr);
  endtask : rd

  // raw comparator high for n cycles, then time for sync, flag and irq to land
  task automatic pulse(input int i, input int n);
    uv[i] <= 1'h1;
    cyc(n);
    uv[i] <= 1'h0;
    cyc(8);
  endtask : pulse

  task automatic do_reset();
    rst <= 1'h1;
    cyc(16);
    rst <= 1'h0;
  endtask : do_reset

  initial begin
    repeat (10000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    fidx = '{IDX_CONV1_FAULT, IDX_CONV2_FAULT, IDX_CONV3_FAULT, IDX_CONV4_FAULT,
             IDX_CONV5_FAULT, IDX_CONV6_FAULT};
    {rst, psel, penable, pwrite, reg_uv, sleep_pin, sleep_request} = 7'h40;
    {paddr, pwdata, pstrb, lp, en, uv} = {44'h0, 4'h3, 15'h0};
    do_reset();
    rd(IDX_UV_STATUS, 32'h0, 1'h0);
    rd(IDX_UV_MASK, 32'h0, 1'h0);
    rd(IDX_ACTIVE_OPT, 32'h0, 1'h0);
    rd(IDX_CONV5_MODE, 32'h8, 1'h0);
    rd(8'h10, 32'h0, 1'h1);
    wr(IDX_ACTIVE_OPT, 16'hffff);
    rd(IDX_ACTIVE_OPT, 32'h3000, 1'h0);
    wr(IDX_CONV2_MODE, 16'hffff);
    rd(IDX_CONV2_MODE, 32'h135f, 1'h0);
    pstrb <= 4'h1;
    wr(IDX_CONV1_FAULT, 16'hc000);
    rd(IDX_CONV1_FAULT, 32'h0, 1'h0);
    pstrb <= 4'h3;
    for (int i = 0; i < 6; i++) begin
      rd(fidx[i], 32'h0, 1'h0);
      wr(fidx[i], 16'hffff);
      rd(fidx[i], 32'hc000, 1'h0);
      wr(fidx[i], 16'h0);
    end
    wr(IDX_ACTIVE_OPT, 16'h0);
    wr(IDX_CONV2_MODE, 16'h0);
    en <= 6'h3f;
    cyc(30);
    for (int i = 0; i < 6; i++) begin
      pulse(i, 12);
      chk1(irq, 1'h1);
      rd(IDX_UV_STATUS, 32'h1 << i, 1'h0);
      cyc(2);
      chk1(irq, 1'h0);
      rd(IDX_UV_STATUS, 32'h0, 1'h0);
    end
    check({26'h0, on}, 32'h3f);
    pulse(0, 2);
    rd(IDX_UV_STATUS, 32'h0, 1'h0);
    wr(IDX_UV_MASK, 16'h1);
    rd(IDX_UV_MASK, 32'h1, 1'h0);
    pulse(0, 12);
    chk1(irq, 1'h0);
    wr(IDX_UV_MASK, 16'h0);
    cyc(2);
    chk1(irq, 1'h1);
    rd(IDX_UV_STATUS, 32'h1, 1'h0);
    wr(IDX_UV_MASK, 16'h3f);
    reg_uv <= 1'h1;
    cyc(5);
    chk1(irq, 1'h1);
    reg_uv <= 1'h0;
    cyc(5);
    chk1(irq, 1'h0);
    wr(IDX_UV_MASK, 16'h0);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_CONV2_MODE, 16'h1000 | 16'(s << 8));
      if (s == 0) wr(IDX_SLEEP_CTRL, 16'h1);
      else lp <= 3'(1 << (s - 1));
      cyc(5);
      check({26'h0, on}, 32'h3d);
      wr(IDX_SLEEP_CTRL, 16'h0);
      lp <= 3'h0;
      cyc(5);
      check({26'h0, on}, 32'h3f);
    end
    wr(IDX_CONV2_MODE, 16'h0300);
    wr(IDX_CONV5_MODE, 16'h1100);
    sleep_pin <= 1'h1;
    cyc(5);
    check({26'h0, on}, 32'h2f);
    sleep_pin <= 1'h0;
    cyc(5);
    check({26'h0, on}, 32'h3f);
    wr(IDX_CONV2_MODE, 16'h1000);
    sleep_request <= 1'h1;
    cyc(3);
    check({26'h0, on}, 32'h3d);
    sleep_request <= 1'h0;
    cyc(3);
    check({26'h0, on}, 32'h3f);
    // code 01 is 40 cycles here; 36 would already trip with code 00
    wr(IDX_ACTIVE_OPT, 16'h1000);
    for (int k = 0; k < 2; k++) begin
      en[2] <= 1'h0;
      cyc(5);
      en[2] <= 1'h1;
      uv[2] <= 1'h1;
      cyc(k ? 60 : 36);
      uv[2] <= 1'h0;
      cyc(8);
      rd(IDX_UV_STATUS, k ? 32'h4 : 32'h0, 1'h0);
    end
    wr(IDX_CONV4_FAULT, 16'h4000);
    pulse(3, 12);
    check({26'h0, on}, 32'h37);
    rd(IDX_BLOCK_STATUS, 32'h437, 1'h0);
    chk1(shut, 1'h0);
    chk1(irq, 1'h1);
    rd(IDX_UV_STATUS, 32'h8, 1'h0);
    en[3] <= 1'h0;
    cyc(5);
    en[3] <= 1'h1;
    cyc(5);
    check({26'h0, on}, 32'h3f);
    for (int c = 2; c < 4; c++) begin
      wr(IDX_CONV6_FAULT, 16'(c) << 14);
      pulse(5, 12);
      chk1(shut, 1'h1);
      check({26'h0, on}, 32'h0);
      chk1(irq, 1'h1);
      do_reset();
      cyc(30);
    end
    conclude();
  end
endmodule : testbench
